// ---- logic/msc_consts.svh ----
// Offsets, reset values and field positions of the MAC statistics block
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH

`define MSC_ADDR_W 16
`define MSC_DATA_W 32

`define MSC_OFS_STAT_CTRL 16'h0100
`define MSC_OFS_RSV_A 16'h010C
`define MSC_OFS_RSV_B 16'h0110
`define MSC_OFS_RX_ALL 16'h0200
`define MSC_OFS_RX_GOOD 16'h0204
`define MSC_OFS_TX_ALL 16'h0300
`define MSC_OFS_TX_BYTES 16'h0308
`define MSC_OFS_TX_GOOD_BYTES 16'h030C
`define MSC_OFS_TX_UNDERRUN 16'h0334
`define MSC_OFS_TX_ABORT 16'h0338

`define MSC_RST_STAT_CTRL 32'h00002F72
`define MSC_RST_RSV 32'h00000000
`define MSC_RST_COUNT 32'h00000000
`define MSC_RSV_INIT 32'hFFFFFFFF
`define MSC_STAT_CTRL_RSV_BIT 1
`define MSC_MAX_FRAME_LSB 3
`define MSC_MAX_FRAME_MSB 13
`define MSC_STAT_CTRL_MASK 32'h00003FFA
`define MSC_INIT_STEPS 2'h3

`endif

// ---- logic/msc_pkg.sv ----
// Types shared by both ends of the MAC statistics link
`include "msc_consts.svh"
package msc_pkg;
    typedef logic [`MSC_DATA_W-1:0] msc_word_t;
    typedef logic [`MSC_ADDR_W-1:0] msc_addr_t;
    typedef enum logic [1:0] {
        MSC_HS_INIT = 2'h0,
        MSC_HS_INIT_WAIT = 2'h1,
        MSC_HS_IDLE = 2'h2,
        MSC_HS_WAIT = 2'h3
    } msc_host_state_e;
endpackage

// ---- logic/msc_link_if.sv ----
// Link between the MAC datapath side and the statistics counter bank
interface msc_link_if
    import msc_pkg::*;
    ();
    logic rx_frame_done;
    logic rx_frame_ok;
    logic tx_frame_done;
    logic tx_byte;
    logic tx_byte_ok;
    logic tx_abort;
    logic tx_abort_underrun;
    logic reg_req;
    logic reg_write;
    msc_addr_t reg_addr;
    msc_word_t reg_wdata;
    logic reg_ack;
    msc_word_t reg_rdata;

    modport device (
        input rx_frame_done, rx_frame_ok, tx_frame_done, tx_byte, tx_byte_ok,
        input tx_abort, tx_abort_underrun, reg_req, reg_write, reg_addr, reg_wdata,
        output reg_ack, reg_rdata
    );
    modport mac (
        output rx_frame_done, rx_frame_ok, tx_frame_done, tx_byte, tx_byte_ok,
        output tx_abort, tx_abort_underrun, reg_req, reg_write, reg_addr, reg_wdata,
        input reg_ack, reg_rdata
    );
endinterface

// ---- logic/msc_counters.sv ----
// Statistics counter bank with its indirect register port
`include "msc_consts.svh"
module msc_counters
    import msc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Link to the MAC datapath side
    msc_link_if.device link,
    // Control words towards the MAC
    output logic [`MSC_DATA_W-1:0] rsv_ctrl_a,
    output logic [`MSC_DATA_W-1:0] rsv_ctrl_b,
    output logic [`MSC_DATA_W-1:0] stat_ctrl,
    output logic [10:0] max_frame_size
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic msc_word_t bump(input msc_word_t v, input logic en);
        msc_word_t r;
        r = v;
        if (en) begin
            r = v + 32'h00000001;
        end
        return r;
    endfunction

    function automatic logic hit(input msc_addr_t a, input msc_addr_t ofs);
        return a == ofs;
    endfunction

    // ------------------------------------------------------------
    // Counter storage
    // ------------------------------------------------------------
    msc_word_t rx_all_frames_tally;
    msc_word_t rx_good_frames_tally;
    msc_word_t tx_all_frames_tally;
    msc_word_t tx_all_bytes_tally;
    msc_word_t tx_good_bytes_tally;
    msc_word_t tx_underrun_abort_tally;
    msc_word_t tx_any_abort_tally;

    logic wr_stb;
    assign wr_stb = link.reg_req & link.reg_write;

    // ------------------------------------------------------------
    // Receive counters
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_all_frames_tally <= `MSC_RST_COUNT;
        end else begin
            rx_all_frames_tally <= bump(rx_all_frames_tally, link.rx_frame_done);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_good_frames_tally <= `MSC_RST_COUNT;
        end else begin
            rx_good_frames_tally <= bump(rx_good_frames_tally,
                link.rx_frame_done & link.rx_frame_ok);
        end
    end

    // ------------------------------------------------------------
    // Transmit frame and byte counters
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_all_frames_tally <= `MSC_RST_COUNT;
        end else begin
            tx_all_frames_tally <= bump(tx_all_frames_tally, link.tx_frame_done);
        end
    end

    // Bytes of later aborted frames are already counted here
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_all_bytes_tally <= `MSC_RST_COUNT;
        end else begin
            tx_all_bytes_tally <= bump(tx_all_bytes_tally, link.tx_byte);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_good_bytes_tally <= `MSC_RST_COUNT;
        end else begin
            tx_good_bytes_tally <= bump(tx_good_bytes_tally,
                link.tx_byte & link.tx_byte_ok);
        end
    end

    // ------------------------------------------------------------
    // Abort counters
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_underrun_abort_tally <= `MSC_RST_COUNT;
        end else begin
            tx_underrun_abort_tally <= bump(tx_underrun_abort_tally,
                link.tx_abort_underrun);
        end
    end

    // Underrun counts as an abort even without the general strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_any_abort_tally <= `MSC_RST_COUNT;
        end else begin
            tx_any_abort_tally <= bump(tx_any_abort_tally,
                link.tx_abort | link.tx_abort_underrun);
        end
    end

    // ------------------------------------------------------------
    // Writable control words
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rsv_ctrl_a <= `MSC_RST_RSV;
        end else if (wr_stb && hit(link.reg_addr, `MSC_OFS_RSV_A)) begin
            rsv_ctrl_a <= link.reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rsv_ctrl_b <= `MSC_RST_RSV;
        end else if (wr_stb && hit(link.reg_addr, `MSC_OFS_RSV_B)) begin
            rsv_ctrl_b <= link.reg_wdata;
        end
    end

    // Only bit one and the frame size field are stored
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_ctrl <= `MSC_RST_STAT_CTRL;
        end else if (wr_stb && hit(link.reg_addr, `MSC_OFS_STAT_CTRL)) begin
            stat_ctrl <= link.reg_wdata & `MSC_STAT_CTRL_MASK;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            max_frame_size <= 11'(`MSC_RST_STAT_CTRL >> `MSC_MAX_FRAME_LSB);
        end else if (wr_stb && hit(link.reg_addr, `MSC_OFS_STAT_CTRL)) begin
            max_frame_size <= link.reg_wdata[`MSC_MAX_FRAME_MSB:`MSC_MAX_FRAME_LSB];
        end
    end

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    msc_word_t next_rdata;

    // Counters are read-only; unmapped addresses read zero
    always_comb begin
        case (link.reg_addr)
            `MSC_OFS_STAT_CTRL: next_rdata = stat_ctrl;
            `MSC_OFS_RSV_A: next_rdata = rsv_ctrl_a;
            `MSC_OFS_RSV_B: next_rdata = rsv_ctrl_b;
            `MSC_OFS_RX_ALL: next_rdata = rx_all_frames_tally;
            `MSC_OFS_RX_GOOD: next_rdata = rx_good_frames_tally;
            `MSC_OFS_TX_ALL: next_rdata = tx_all_frames_tally;
            `MSC_OFS_TX_BYTES: next_rdata = tx_all_bytes_tally;
            `MSC_OFS_TX_GOOD_BYTES: next_rdata = tx_good_bytes_tally;
            `MSC_OFS_TX_UNDERRUN: next_rdata = tx_underrun_abort_tally;
            `MSC_OFS_TX_ABORT: next_rdata = tx_any_abort_tally;
            default: next_rdata = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------
    // Answer to the register port
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link.reg_ack <= 1'b0;
        end else begin
            link.reg_ack <= link.reg_req;
        end
    end

    // Whole word latched on one edge, so no byte can mix old and new
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link.reg_rdata <= 32'h00000000;
        end else if (link.reg_req && !link.reg_write) begin
            link.reg_rdata <= next_rdata;
        end
    end

endmodule

// ---- logic/msc_host.sv ----
// MAC datapath side: event strobes, control word setup and register access
`include "msc_consts.svh"
module msc_host
    import msc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Link to the counter bank
    msc_link_if.mac link,
    // Datapath events
    input wire logic ev_rx_frame_done,
    input wire logic ev_rx_frame_ok,
    input wire logic ev_tx_frame_done,
    input wire logic ev_tx_byte,
    input wire logic ev_tx_byte_ok,
    input wire logic ev_tx_abort,
    input wire logic ev_tx_abort_underrun,
    // Register command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [`MSC_ADDR_W-1:0] cmd_addr,
    input wire logic [`MSC_DATA_W-1:0] cmd_wdata,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [`MSC_DATA_W-1:0] rsp_data,
    output logic init_done
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic msc_addr_t init_addr(input logic [1:0] step);
        case (step)
            2'h0: return `MSC_OFS_RSV_A;
            2'h1: return `MSC_OFS_RSV_B;
            default: return `MSC_OFS_STAT_CTRL;
        endcase
    endfunction

    // Control register writes always carry bit one set
    function automatic msc_word_t fix_data(input msc_addr_t a, input msc_word_t d);
        msc_word_t r;
        r = d;
        if (a == `MSC_OFS_STAT_CTRL) begin
            r[`MSC_STAT_CTRL_RSV_BIT] = 1'b1;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Event strobes
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link.rx_frame_done <= 1'b0;
            link.rx_frame_ok <= 1'b0;
            link.tx_frame_done <= 1'b0;
            link.tx_byte <= 1'b0;
            link.tx_byte_ok <= 1'b0;
            link.tx_abort <= 1'b0;
            link.tx_abort_underrun <= 1'b0;
        end else begin
            link.rx_frame_done <= ev_rx_frame_done;
            link.rx_frame_ok <= ev_rx_frame_ok;
            link.tx_frame_done <= ev_tx_frame_done;
            link.tx_byte <= ev_tx_byte;
            link.tx_byte_ok <= ev_tx_byte_ok;
            link.tx_abort <= ev_tx_abort;
            link.tx_abort_underrun <= ev_tx_abort_underrun;
        end
    end

    // ------------------------------------------------------------
    // Setup sequence and command handling
    // ------------------------------------------------------------
    msc_host_state_e state;
    logic [1:0] step;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= MSC_HS_INIT;
            step <= 2'h0;
            link.reg_req <= 1'b0;
            link.reg_write <= 1'b0;
            link.reg_addr <= 16'h0000;
            link.reg_wdata <= 32'h00000000;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 32'h00000000;
            init_done <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (state)
                MSC_HS_INIT: begin
                    link.reg_req <= 1'b1;
                    link.reg_write <= 1'b1;
                    link.reg_addr <= init_addr(step);
                    if (step == 2'h2) begin
                        link.reg_wdata <= fix_data(`MSC_OFS_STAT_CTRL,
                            `MSC_RST_STAT_CTRL);
                    end else begin
                        link.reg_wdata <= `MSC_RSV_INIT;
                    end
                    state <= MSC_HS_INIT_WAIT;
                end
                MSC_HS_INIT_WAIT: begin
                    link.reg_req <= 1'b0;
                    if (link.reg_ack) begin
                        if (step == 2'h2) begin
                            state <= MSC_HS_IDLE;
                            init_done <= 1'b1;
                            cmd_ready <= 1'b1;
                        end else begin
                            step <= step + 2'h1;
                            state <= MSC_HS_INIT;
                        end
                    end
                end
                MSC_HS_IDLE: begin
                    if (cmd_valid && cmd_ready) begin
                        link.reg_req <= 1'b1;
                        link.reg_write <= cmd_write;
                        link.reg_addr <= cmd_addr;
                        link.reg_wdata <= fix_data(cmd_addr, cmd_wdata);
                        cmd_ready <= 1'b0;
                        state <= MSC_HS_WAIT;
                    end
                end
                MSC_HS_WAIT: begin
                    link.reg_req <= 1'b0;
                    if (link.reg_ack) begin
                        rsp_valid <= 1'b1;
                        rsp_data <= link.reg_rdata;
                        cmd_ready <= 1'b1;
                        state <= MSC_HS_IDLE;
                    end
                end
                default: begin
                    state <= MSC_HS_INIT;
                end
            endcase
        end
    end

endmodule

// ---- testbench/msc_link_props.sv ----
// Concurrent checks on the link between the datapath side and the counter bank
`include "msc_consts.svh"
module msc_link_props
    import msc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Event strobes
    input wire logic rx_frame_done,
    input wire logic rx_frame_ok,
    input wire logic tx_frame_done,
    input wire logic tx_byte,
    input wire logic tx_byte_ok,
    input wire logic tx_abort,
    input wire logic tx_abort_underrun,
    // Register port
    input wire logic reg_req,
    input wire logic reg_write,
    input wire msc_addr_t reg_addr,
    input wire msc_word_t reg_wdata,
    input wire logic reg_ack,
    input wire msc_word_t reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Helper state
    // ----
    logic rd;
    logic any_ev;
    logic is_cnt;
    logic unmapped;
    logic rd_q;
    logic quiet;
    logic [1:0] req_seen;
    msc_addr_t last_addr;
    msc_word_t last_data;
    msc_word_t sh_a;
    msc_word_t sh_b;
    assign rd = reg_req & ~reg_write;
    assign any_ev = rx_frame_done | tx_frame_done | tx_byte | tx_abort | tx_abort_underrun;
    assign is_cnt = reg_addr inside {`MSC_OFS_RX_ALL, `MSC_OFS_RX_GOOD, `MSC_OFS_TX_ALL,
        `MSC_OFS_TX_BYTES, `MSC_OFS_TX_GOOD_BYTES, `MSC_OFS_TX_UNDERRUN, `MSC_OFS_TX_ABORT};
    assign unmapped = !is_cnt && !(reg_addr inside {`MSC_OFS_STAT_CTRL, `MSC_OFS_RSV_A,
        `MSC_OFS_RSV_B});
    // Last read of any address, its answer, and whether no strobe other than rx_frame_ok or tx_byte_ok came since
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_q <= 1'b0;
            quiet <= 1'b0;
            last_addr <= '0;
            last_data <= '0;
        end else begin
            rd_q <= rd;
            if (rd_q) begin
                last_data <= reg_rdata;
            end
            if (rd) begin
                last_addr <= reg_addr;
                quiet <= ~any_ev;
            end else if (any_ev) begin
                quiet <= 1'b0;
            end
        end
    end
    // Shadow of the reserved words
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sh_a <= `MSC_RST_RSV;
            sh_b <= `MSC_RST_RSV;
        end else if (reg_req && reg_write && reg_addr == `MSC_OFS_RSV_A) begin
            sh_a <= reg_wdata;
        end else if (reg_req && reg_write && reg_addr == `MSC_OFS_RSV_B) begin
            sh_b <= reg_wdata;
        end
    end
    // Requests seen since reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            req_seen <= 2'h0;
        end else if (reg_req && req_seen != 2'h3) begin
            req_seen <= req_seen + 2'h1;
        end
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_ack_next;
        reg_req |=> reg_ack;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_cause;
        reg_ack |-> $past(reg_req);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_rdata_hold;
        !rd |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_read_pure;
        rd && is_cnt && !rd_q && quiet && reg_addr == last_addr |=> reg_rdata == last_data;
    endproperty
    a_read_pure: assert property (p_read_pure) else $error("count changed");
    property p_rsv_rw;
        rd && (reg_addr == `MSC_OFS_RSV_A || reg_addr == `MSC_OFS_RSV_B)
            |=> reg_rdata == (($past(reg_addr) == `MSC_OFS_RSV_A) ? sh_a : sh_b);
    endproperty
    a_rsv_rw: assert property (p_rsv_rw) else $error("reserved word lost");
    property p_unmapped_zero;
        rd && unmapped |=> reg_rdata == '0;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped not zero");
    property p_init_first;
        reg_req && req_seen == 2'h0
            |-> reg_write && reg_addr == `MSC_OFS_RSV_A && reg_wdata == `MSC_RSV_INIT;
    endproperty
    a_init_first: assert property (p_init_first) else $error("first setup write bad");
    property p_init_second;
        reg_req && req_seen == 2'h1
            |-> reg_write && reg_addr == `MSC_OFS_RSV_B && reg_wdata == `MSC_RSV_INIT;
    endproperty
    a_init_second: assert property (p_init_second) else $error("second setup bad");
    property p_ctrl_bit1;
        reg_req && reg_write && reg_addr == `MSC_OFS_STAT_CTRL |-> reg_wdata[1];
    endproperty
    a_ctrl_bit1: assert property (p_ctrl_bit1) else $error("control bit one clear");
    c_count_read: cover property (rd && is_cnt);
    c_pure_read: cover property (rd && is_cnt && !rd_q && quiet && reg_addr == last_addr);
    c_rsv_write: cover property (reg_req && reg_write && reg_addr == `MSC_OFS_RSV_A);
endmodule

// ---- testbench/test_mac_statistics_counters.sv ----
// Self-checking bench for the counter bank and its datapath side
`include "msc_consts.svh"
module test_mac_statistics_counters
    import msc_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk;
    logic arst_n;
    logic [6:0] ev;
    logic cmd_valid;
    logic cmd_write;
    msc_addr_t cmd_addr;
    msc_word_t cmd_wdata;
    logic cmd_ready;
    logic rsp_valid;
    msc_word_t rsp_data;
    logic init_done;
    msc_word_t rsv_a;
    msc_word_t rsv_b;
    logic [10:0] max_frame;
    msc_word_t stat_word;
    msc_word_t base_cnt;
    msc_word_t now_cnt;
    int miscompares;
    int comparisons;
    msc_word_t exp_cnt [7];
    msc_addr_t cnt_addr [7] = '{`MSC_OFS_RX_ALL, `MSC_OFS_RX_GOOD, `MSC_OFS_TX_ALL,
        `MSC_OFS_TX_BYTES, `MSC_OFS_TX_GOOD_BYTES, `MSC_OFS_TX_UNDERRUN, `MSC_OFS_TX_ABORT};
    logic [6:0] modes [11] = '{7'h01, 7'h03, 7'h02, 7'h04, 7'h08, 7'h18, 7'h10, 7'h20, 7'h40,
        7'h60, 7'h7F};
    int lens [11] = '{3, 2, 2, 1, 5, 4, 2, 2, 3, 1, 6};
    // ----
    // Both ends and the checker
    // ----
    msc_link_if msc_link_if_inst ();
    msc_counters msc_counters_inst (.clk(clk), .arst_n(arst_n), .link(msc_link_if_inst.device),
        .rsv_ctrl_a(rsv_a), .rsv_ctrl_b(rsv_b), .stat_ctrl(stat_word), .max_frame_size(max_frame));
    msc_host msc_host_inst (.clk(clk), .arst_n(arst_n), .link(msc_link_if_inst.mac),
        .ev_rx_frame_done(ev[0]), .ev_rx_frame_ok(ev[1]), .ev_tx_frame_done(ev[2]),
        .ev_tx_byte(ev[3]), .ev_tx_byte_ok(ev[4]), .ev_tx_abort(ev[5]),
        .ev_tx_abort_underrun(ev[6]), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .init_done(init_done));
    msc_link_props msc_link_props_inst (.clk(clk), .arst_n(arst_n),
        .rx_frame_done(msc_link_if_inst.rx_frame_done), .rx_frame_ok(msc_link_if_inst.rx_frame_ok),
        .tx_frame_done(msc_link_if_inst.tx_frame_done), .tx_byte(msc_link_if_inst.tx_byte),
        .tx_byte_ok(msc_link_if_inst.tx_byte_ok), .tx_abort(msc_link_if_inst.tx_abort),
        .tx_abort_underrun(msc_link_if_inst.tx_abort_underrun),
        .reg_req(msc_link_if_inst.reg_req), .reg_write(msc_link_if_inst.reg_write),
        .reg_addr(msc_link_if_inst.reg_addr), .reg_wdata(msc_link_if_inst.reg_wdata),
        .reg_ack(msc_link_if_inst.reg_ack), .reg_rdata(msc_link_if_inst.reg_rdata));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ----
    // Tasks
    // ----
    task automatic chk(input msc_word_t got, input msc_word_t want);
        comparisons++;
        if (got !== want) begin
            $display("Error at %0t: got %h expected %h", $time, got, want);
            miscompares++;
        end
    endtask
    task automatic cmd(input logic wr, input msc_addr_t a, input msc_word_t d, output msc_word_t q);
        int n;
        n = 0;
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr = a;
        cmd_wdata = d;
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({31'h0, rsp_valid}, 32'h00000001);
        q = rsp_data;
    endtask
    task automatic rd_chk(input msc_addr_t a, input msc_word_t want);
        msc_word_t q;
        cmd(1'b0, a, 32'h00000000, q);
        chk(q, want);
    endtask
    task automatic wr(input msc_addr_t a, input msc_word_t d);
        msc_word_t q;
        cmd(1'b1, a, d, q);
    endtask
    task automatic burst(input logic [6:0] v, input int n);
        repeat (n) begin
            ev = v;
            exp_cnt[0] += 32'(v[0]);
            exp_cnt[1] += 32'(v[0] & v[1]);
            exp_cnt[2] += 32'(v[2]);
            exp_cnt[3] += 32'(v[3]);
            exp_cnt[4] += 32'(v[3] & v[4]);
            exp_cnt[5] += 32'(v[6]);
            exp_cnt[6] += 32'(v[5] | v[6]);
            @(posedge clk);
            #1;
        end
        ev = 7'h00;
        @(posedge clk);
        #1;
    endtask
    task automatic check_all();
        for (int i = 0; i < 7; i++) begin
            rd_chk(cnt_addr[i], exp_cnt[i]);
        end
    endtask
    task automatic do_reset();
        int n;
        n = 0;
        arst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        arst_n = 1'b1;
        foreach (exp_cnt[i]) begin
            exp_cnt[i] = '0;
        end
        while (init_done !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({31'h0, init_done}, 32'h00000001);
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        #400000;
        miscompares++;
        tally_and_finish();
    end
    initial begin
        miscompares = 0;
        comparisons = 0;
        ev = 7'h00;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = '0;
        cmd_wdata = '0;
        do_reset();
        chk(rsv_a, `MSC_RSV_INIT);
        chk(rsv_b, `MSC_RSV_INIT);
        chk(32'(max_frame), (`MSC_RST_STAT_CTRL >> 3) & 32'h000007FF);
        chk(stat_word, `MSC_RST_STAT_CTRL);
        rd_chk(`MSC_OFS_RSV_A, `MSC_RSV_INIT);
        rd_chk(`MSC_OFS_RSV_B, `MSC_RSV_INIT);
        rd_chk(`MSC_OFS_STAT_CTRL, `MSC_RST_STAT_CTRL);
        check_all();
        for (int i = 0; i < 11; i++) begin
            burst(modes[i], lens[i]);
        end
        check_all();
        wr(cnt_addr[6], 32'hA5A5A5A5);
        rd_chk(cnt_addr[6], exp_cnt[6]);
        for (int i = 0; i < 7; i++) begin
            wr(cnt_addr[i], 32'hFFFFFFFF);
        end
        check_all();
        wr(`MSC_OFS_STAT_CTRL, 32'h00000000);
        rd_chk(`MSC_OFS_STAT_CTRL, 32'h00000002);
        wr(`MSC_OFS_STAT_CTRL, 32'hFFFFFFFF);
        rd_chk(`MSC_OFS_STAT_CTRL, `MSC_STAT_CTRL_MASK);
        chk(stat_word, `MSC_STAT_CTRL_MASK);
        chk(32'(max_frame), (`MSC_STAT_CTRL_MASK >> 3) & 32'h000007FF);
        wr(`MSC_OFS_RSV_A, 32'h12345678);
        rd_chk(`MSC_OFS_RSV_A, 32'h12345678);
        wr(`MSC_OFS_RSV_A, `MSC_RSV_INIT);
        wr(16'h0400, 32'hFFFFFFFF);
        rd_chk(16'h0400, 32'h00000000);
        rd_chk(16'h0304, 32'h00000000);
        cmd(1'b0, cnt_addr[3], 32'h00000000, base_cnt);
        burst(7'h7F, 5);
        cmd(1'b0, cnt_addr[3], 32'h00000000, now_cnt);
        chk(now_cnt - base_cnt, 32'h00000005);
        do_reset();
        check_all();
        rd_chk(`MSC_OFS_RSV_B, `MSC_RSV_INIT);
        tally_and_finish();
    end
endmodule
